// ---- hdl/irq_combiner_map.svh ----
`ifndef IRQ_COMBINER_MAP_SVH
`define IRQ_COMBINER_MAP_SVH

// combiner registers
`define REG_COMBINER_CONTROL 8'h04
`define REG_PACING_COUNT 8'h08
// management-serial event registers, interrupt vector and phy select registers
`define REG_LINK_RAW 8'h10
`define REG_LINK_MASKED 8'h14
`define REG_ACCESS_RAW 8'h20
`define REG_ACCESS_MASKED 8'h24
`define REG_ACCESS_MASK_SET 8'h28
`define REG_ACCESS_MASK_CLEAR 8'h2C
`define REG_IRQ_VECTOR 8'h40
`define REG_PHY_SELECT0 8'h84
`define REG_PHY_SELECT1 8'h8C

// field positions
`define GLOBAL_EN_BIT 0
`define PACING_WIDTH 18
`define LINK_EN_BIT 6
`define PHY_ADDR_LSB 0
`define PHY_ADDR_WIDTH 5

// reset values
`define RESET_CONTROL 1'h0
`define RESET_PACING 18'h00000

// vector layout
`define VEC_TX_LSB 0
`define VEC_RX_LSB 8
`define VEC_STAT_BIT 16
`define VEC_HOST_BIT 17
`define VEC_LINK_BIT 18
`define VEC_ACCESS_BIT 19
`define VEC_WIDTH 20

`endif

// ---- hdl/irq_combiner_pkg.sv ----
package irq_combiner_pkg;
	typedef enum logic {
		pace_idle,
		pace_running
	} pace_state_t;
endpackage

// ---- hdl/event_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
// one event channel: raw and masked sticky bits, write-one-to-clear
module event_channel (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// event and mask
	input wire logic event_i,
	input wire logic enable_i,
	input wire logic clear_i,
	// status
	output logic raw_o,
	output logic masked_o
);
	// a set arriving with the clear wins, so no event is lost
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			raw_o <= 1'b0;
			masked_o <= 1'b0;
		end else begin
			raw_o <= event_i | (raw_o & ~clear_i);
			masked_o <= (event_i & enable_i) | (masked_o & ~clear_i);
		end
	end
endmodule
`default_nettype wire

// ---- hdl/emac_mdio_irq_combiner.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "irq_combiner_map.svh"
module emac_mdio_irq_combiner
	import irq_combiner_pkg::*;
#(
	parameter int NUM_CH = 8,
	parameter int NUM_PHY = 32
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	output logic [31:0] reg_rdata_o,
	// mac level sources, same clock
	input wire logic [NUM_CH-1:0] tx_done_irq_i,
	input wire logic [NUM_CH-1:0] rx_done_irq_i,
	input wire logic statistics_irq_i,
	input wire logic host_error_irq_i,
	// management-serial state, same clock
	input wire logic [NUM_PHY-1:0] phy_link_state_i,
	input wire logic [1:0] user_access_go_i,
	// cpu interrupt, to cpu_irq_input_43
	output logic combined_irq_out_o,
	// management event levels
	output logic link_change_irq_o,
	output logic access_done_irq_o
);
	localparam int PW = `PACING_WIDTH;

	logic global_irq_enable;
	logic global_irq_enable_q;
	logic [PW-1:0] irq_pacing_count;
	logic [PW-1:0] pace_counter;
	pace_state_t pace_state;
	logic [4:0] monitored_phy_address [2];
	logic [1:0] link_irq_enable;
	logic [1:0] link_state_q;
	logic [1:0] go_q;
	logic [1:0] access_irq_mask_set;
	logic [1:0] link_irq_raw_status;
	logic [1:0] link_irq_masked_status;
	logic [1:0] access_irq_raw_status;
	logic [1:0] access_irq_masked_status;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic stb);
		hit = stb & (a == off);
	endfunction

	// decode
	wire wr_control = hit(reg_addr_i, `REG_COMBINER_CONTROL, reg_write_i);
	wire wr_pacing = hit(reg_addr_i, `REG_PACING_COUNT, reg_write_i);
	wire wr_link_masked = hit(reg_addr_i, `REG_LINK_MASKED, reg_write_i);
	wire wr_access_masked = hit(reg_addr_i, `REG_ACCESS_MASKED, reg_write_i);
	wire wr_mask_set = hit(reg_addr_i, `REG_ACCESS_MASK_SET, reg_write_i);
	wire wr_mask_clear = hit(reg_addr_i, `REG_ACCESS_MASK_CLEAR, reg_write_i);
	wire [1:0] wr_phy_sel;
	assign wr_phy_sel[0] = hit(reg_addr_i, `REG_PHY_SELECT0, reg_write_i);
	assign wr_phy_sel[1] = hit(reg_addr_i, `REG_PHY_SELECT1, reg_write_i);

	// per-channel events
	wire [1:0] link_now;
	wire [1:0] link_event;
	wire [1:0] access_event;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			assign link_now[g] = phy_link_state_i[monitored_phy_address[g]];
			// monitored link change gated by its enable
			assign link_event[g] = (link_now[g] != link_state_q[g]) & link_irq_enable[g];
			// go falling edge gated by the mask set bit
			assign access_event[g] = go_q[g] & ~user_access_go_i[g] & access_irq_mask_set[g];

			// bit g of the link registers belongs to select register g
			event_channel u_link (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.event_i(link_event[g]),
				.enable_i(1'b1),
				.clear_i(wr_link_masked & reg_wdata_i[g]),
				.raw_o(link_irq_raw_status[g]),
				.masked_o(link_irq_masked_status[g])
			);
			// bit g of the access registers belongs to user access g
			event_channel u_access (
				.clk_sys_i(clk_sys_i),
				.rst_i(rst_i),
				.event_i(access_event[g]),
				.enable_i(1'b1),
				.clear_i(wr_access_masked & reg_wdata_i[g]),
				.raw_o(access_irq_raw_status[g]),
				.masked_o(access_irq_masked_status[g])
			);
		end
	endgenerate

	// new monitored address of each select register, as written
	wire [4:0] new_phy_address = reg_wdata_i[`PHY_ADDR_LSB +: `PHY_ADDR_WIDTH];
	// link state of the newly selected phy, so a re-point is not seen as a link change
	wire new_phy_link = phy_link_state_i[new_phy_address];

	// one process for both channels keeps every variable single-driven
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			monitored_phy_address[0] <= 5'h00;
			monitored_phy_address[1] <= 5'h00;
			link_irq_enable <= 2'h0;
			link_state_q <= 2'h0;
			go_q <= 2'h0;
		end else begin
			go_q <= user_access_go_i;
			for (int i = 0; i < 2; i++) begin
				if (wr_phy_sel[i]) begin
					monitored_phy_address[i] <= new_phy_address;
					link_irq_enable[i] <= reg_wdata_i[`LINK_EN_BIT];
					link_state_q[i] <= new_phy_link;
				end else begin
					link_state_q[i] <= link_now[i];
				end
			end
		end
	end

	// only two management event kinds exist
	wire next_link_irq = |link_irq_masked_status;
	wire next_access_irq = |access_irq_masked_status;

	// vector of all 20 source levels
	wire [`VEC_WIDTH-1:0] irq_vector_status = {next_access_irq, next_link_irq, host_error_irq_i,
		statistics_irq_i, rx_done_irq_i, tx_done_irq_i};
	// every source merged into one
	wire any_source = |irq_vector_status;

	// pacing counter loads on enable rising only
	wire enable_rise = global_irq_enable & ~global_irq_enable_q;
	wire pace_zero = (pace_counter == '0);
	// gated by enable and a zero counter
	wire next_combined = global_irq_enable & pace_zero & any_source;

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			global_irq_enable <= `RESET_CONTROL;
			irq_pacing_count <= `RESET_PACING;
			access_irq_mask_set <= 2'h0;
		end else begin
			if (wr_control)
				global_irq_enable <= reg_wdata_i[`GLOBAL_EN_BIT];
			if (wr_pacing)
				irq_pacing_count <= {1'b0, reg_wdata_i[PW-2:0]};
			if (wr_mask_set)
				access_irq_mask_set <= access_irq_mask_set | reg_wdata_i[1:0];
			else if (wr_mask_clear)
				access_irq_mask_set <= access_irq_mask_set & ~reg_wdata_i[1:0];
		end
	end

	// pacing state: reload on enable rise, count down each clock
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			global_irq_enable_q <= 1'b0;
			pace_counter <= '0;
			pace_state <= pace_idle;
		end else begin
			global_irq_enable_q <= global_irq_enable;
			case (pace_state)
				pace_idle: begin
					if (enable_rise && irq_pacing_count != '0) begin
						pace_counter <= irq_pacing_count;
						pace_state <= pace_running;
					end
				end
				pace_running: begin
					// a fresh enable with a nonzero pacing count restarts the count, even mid-count
					if (enable_rise && irq_pacing_count != '0) begin
						pace_counter <= irq_pacing_count;
					end else begin
						if (pace_counter == {{(PW-1){1'b0}}, 1'b1})
							pace_state <= pace_idle;
						pace_counter <= pace_counter - 1'b1;
					end
				end
				default: pace_state <= pace_idle;
			endcase
		end
	end

	// registered output: disable then re-enable gives a fresh clean edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			combined_irq_out_o <= 1'b0;
			link_change_irq_o <= 1'b0;
			access_done_irq_o <= 1'b0;
		end else begin
			combined_irq_out_o <= next_combined;
			link_change_irq_o <= next_link_irq;
			access_done_irq_o <= next_access_irq;
		end
	end

	// read mux; unmapped addresses read zero
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (reg_addr_i)
			`REG_COMBINER_CONTROL: next_rdata[`GLOBAL_EN_BIT] = global_irq_enable;
			`REG_PACING_COUNT: next_rdata[PW-1:0] = irq_pacing_count;
			`REG_LINK_RAW: next_rdata[1:0] = link_irq_raw_status;
			`REG_LINK_MASKED: next_rdata[1:0] = link_irq_masked_status;
			`REG_ACCESS_RAW: next_rdata[1:0] = access_irq_raw_status;
			`REG_ACCESS_MASKED: next_rdata[1:0] = access_irq_masked_status;
			`REG_ACCESS_MASK_SET: next_rdata[1:0] = access_irq_mask_set;
			`REG_ACCESS_MASK_CLEAR: next_rdata[1:0] = access_irq_mask_set;
			`REG_IRQ_VECTOR: next_rdata[`VEC_WIDTH-1:0] = irq_vector_status;
			`REG_PHY_SELECT0: begin
				next_rdata[`PHY_ADDR_LSB +: `PHY_ADDR_WIDTH] = monitored_phy_address[0];
				next_rdata[`LINK_EN_BIT] = link_irq_enable[0];
			end
			`REG_PHY_SELECT1: begin
				next_rdata[`PHY_ADDR_LSB +: `PHY_ADDR_WIDTH] = monitored_phy_address[1];
				next_rdata[`LINK_EN_BIT] = link_irq_enable[1];
			end
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			reg_rdata_o <= 32'h0000_0000;
		else if (reg_read_i)
			reg_rdata_o <= next_rdata;
		else
			reg_rdata_o <= 32'h0000_0000;
	end
endmodule
`default_nettype wire

// ---- dv/irq_combiner_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module irq_combiner_props #(
	parameter int NUM_CH = 8,
	parameter int NUM_PHY = 32
) (
	input wire logic clk_sys_i, rst_i, reg_write_i, reg_read_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i, reg_rdata_o,
	input wire logic [NUM_CH-1:0] tx_done_irq_i, rx_done_irq_i,
	input wire logic statistics_irq_i, host_error_irq_i,
	input wire logic [NUM_PHY-1:0] phy_link_state_i,
	input wire logic [1:0] user_access_go_i,
	input wire logic combined_irq_out_o, link_change_irq_o, access_done_irq_o
);
	logic en;
	logic [16:0] pace;
	wire logic mac = |{tx_done_irq_i, rx_done_irq_i, statistics_irq_i, host_error_irq_i};
	// shadow copies from the bus, so no internal probes are needed
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			en <= 1'b0;
			pace <= 17'h00000;
		end else if (reg_write_i && reg_addr_i == 8'h04) en <= reg_wdata_i[0];
		else if (reg_write_i && reg_addr_i == 8'h08) pace <= reg_wdata_i[16:0];
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	AST_RD_IDLE: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0) else $error("rdata not idle");
	AST_CTRL_RD: assert property ($past(reg_read_i && reg_addr_i == 8'h04) |-> reg_rdata_o == {31'h0, $past(en)})
		else $error("control read");
	AST_OFF: assert property (!en |=> !combined_irq_out_o) else $error("irq while disabled");
	AST_ANY: assert property (combined_irq_out_o |-> $past(mac) || link_change_irq_o || access_done_irq_o)
		else $error("irq without source");
	AST_ON: assert property (en && pace == 17'h0 && mac |=> combined_irq_out_o) else $error("irq missing");
	// the first two cycles after enable are left open: the load edge is a designer choice
	AST_PACE: assert property ($rose(en) && pace >= 17'd8 |-> ##3 !combined_irq_out_o [*8])
		else $error("pacing not blocking");
	AST_PACE_END: assert property ($rose(en) && pace == 17'd20 && statistics_irq_i |-> ##[18:26] combined_irq_out_o)
		else $error("pacing too long");
	AST_ACC: assert property ($rose(access_done_irq_o) |-> |($past(user_access_go_i, 3) & ~$past(user_access_go_i, 2)))
		else $error("access irq without go fall");
	AST_LINK: assert property ($rose(link_change_irq_o) |-> $past(phy_link_state_i, 3) != $past(phy_link_state_i, 2))
		else $error("link irq without change");
	cover property ($rose(combined_irq_out_o));
	cover property ($rose(access_done_irq_o));
	cover property ($rose(link_change_irq_o));
endmodule
bind emac_mdio_irq_combiner irq_combiner_props #(.NUM_CH(NUM_CH), .NUM_PHY(NUM_PHY)) chk (.*);
`default_nettype wire

// ---- dv/cpu_irq_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// cpu side: only rising edges count, a held level is one interrupt
module cpu_irq_model (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic irq_i,
	output logic [7:0] edges_o
);
	logic last;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			last <= 1'b0;
			edges_o <= 8'h00;
		end else begin
			last <= irq_i;
			if (irq_i && !last) edges_o <= edges_o + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- dv/tb_emac_mdio_irq_combiner.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_emac_mdio_irq_combiner;
	typedef struct packed {logic [17:0] src; logic [19:0] vec; logic irq;} row_t;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, wr = 1'b0, rd = 1'b0, stat = 1'b0, host = 1'b0;
	logic [7:0] addr = 8'h00, tx = 8'h00, rx = 8'h00, edges;
	logic [31:0] wdata = 32'h0, rdata, n, phy = 32'h0;
	logic [1:0] go = 2'h0;
	logic irq, lnk, acc;
	int failures = 0, compares = 0;
	row_t rows [8] = '{'{18'h00000, 20'h00000, 1'b0}, '{18'h00001, 20'h00001, 1'b1},
		'{18'h00080, 20'h00080, 1'b1}, '{18'h00100, 20'h00100, 1'b1}, '{18'h08000, 20'h08000, 1'b1},
		'{18'h10000, 20'h10000, 1'b1}, '{18'h20000, 20'h20000, 1'b1}, '{18'h3FFFF, 20'h3FFFF, 1'b1}};
	emac_mdio_irq_combiner uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .tx_done_irq_i(tx), .rx_done_irq_i(rx),
		.statistics_irq_i(stat), .host_error_irq_i(host), .phy_link_state_i(phy), .user_access_go_i(go),
		.combined_irq_out_o(irq), .link_change_irq_o(lnk), .access_done_irq_o(acc));
	cpu_irq_model cpu (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .irq_i(irq), .edges_o(edges));
	initial forever #5 clk_sys_i = ~clk_sys_i;
	task automatic report_and_stop;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 cmp(rdata, e);
	endtask
	// go high for one cycle then low: the falling edge marks completion
	task automatic fall(input logic [1:0] g);
		@(posedge clk_sys_i);
		go <= g;
		@(posedge clk_sys_i);
		go <= 2'h0;
		tick(3);
	endtask
	initial begin
		#20000;
		failures++;
		report_and_stop;
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		wr32(8'h04, 32'h1);
		foreach (rows[i]) begin
			@(posedge clk_sys_i);
			{host, stat, rx, tx} <= rows[i].src;
			chk(8'h40, {12'h0, rows[i].vec});
			cmp({31'h0, irq}, {31'h0, rows[i].irq});
		end
		n = {24'h0, edges};
		wr32(8'h04, 32'h0);
		tick(2);
		cmp({31'h0, irq}, 32'h0);
		wr32(8'h04, 32'h1);
		tick(3);
		cmp({24'h0, edges}, n + 32'h1);
		// mid-run reset, with the sources dropped in the same step, must clear control and pacing
		rst_i <= 1'b1;
		{host, stat, rx, tx} <= 18'h0;
		tick(2);
		rst_i <= 1'b0;
		chk(8'h04, 32'h0);
		chk(8'h08, 32'h0);
		wr32(8'h08, 32'hFFFFFFFF);
		chk(8'h08, 32'h0001FFFF);
		wr32(8'h08, 32'h0);
		wr32(8'h04, 32'hFFFFFFFF);
		chk(8'h04, 32'h1);
		chk(8'hFC, 32'h0);
		wr32(8'h28, 32'h1);
		fall(2'h1);
		chk(8'h20, 32'h1);
		chk(8'h24, 32'h1);
		cmp({30'h0, acc, irq}, 32'h3);
		wr32(8'h24, 32'h1);
		chk(8'h24, 32'h0);
		fall(2'h2);
		chk(8'h20, 32'h0);
		wr32(8'h28, 32'h2);
		fall(2'h2);
		chk(8'h24, 32'h2);
		wr32(8'h24, 32'h2);
		wr32(8'h8C, 32'h45);
		@(posedge clk_sys_i);
		phy <= 32'h20;
		tick(3);
		chk(8'h10, 32'h2);
		chk(8'h14, 32'h2);
		cmp({31'h0, lnk}, 32'h1);
		wr32(8'h14, 32'h2);
		chk(8'h14, 32'h0);
		wr32(8'h04, 32'h0);
		wr32(8'h08, 32'h14);
		stat <= 1'b1;
		wr32(8'h04, 32'h1);
		tick(10);
		cmp({31'h0, irq}, 32'h0);
		n = 32'h0;
		while (irq !== 1'b1 && n < 32'd40) begin
			tick(1);
			n = n + 32'h1;
		end
		cmp({31'h0, irq}, 32'h1);
		report_and_stop;
	end
endmodule
`default_nettype wire
